// File: rtl/rtcf_control.sv
// Overview of operation
// - rate code 0 never fires; 3..F double from 122 us; 1,2 alias 8,9
// - inhibit bit 7 set suspends the once-per-second time advance
// - periodic flag reaches the request only when bit 6 enables it
// - alarm flag reaches the request only when bit 5 enables it
// - update-ended flag reaches the request only when bit 4 enables it
// - bit 2 selects binary when one, BCD when zero, for presented values
// - bit 1 one selects 24-hour form 0..23 with AM/PM held off
// - bit 1 zero selects 12-hour form 1..12 with AM/PM indicator
// - bit 0 enables yearly daylight-savings hour adjustment
// - format bits act only on conversion, never on stored contents
// - format bits may toggle at any time without side effects
// - request flag reads one when any enabled event flag is set
// - reading the flag register clears request and event flags
// - periodic flag sets on every periodic event regardless of enable
// - mode control and flags reset to zero
// - rate code sits in bits 3..0 of rate register, reset zero
// - alarm flag sets on every alarm regardless of enable
// - update-ended flag sets when an update completes, regardless of enable
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module rtcf_control
	import rtcf_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       tick_32k,
	input  wire logic       second_tick,
	input  wire logic       alarm_event,
	input  wire logic       update_done,
	output logic            update_advance,
	output logic            binary_mode,
	output logic            hour_24_mode,
	output logic            dst_enable,
	output logic            irq
);
	import rtcf_pkg::*;

	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic [3:0] rate_reg;
	logic [2:0] flags_reg;
	logic [2:0] flags_next;
	logic [2:0] enables;
	logic       req_flag;
	logic       periodic_event;
	logic       flags_read;

	// ----------------------------------------
	// periodic event source
	// ----------------------------------------
	rtcf_periodic_gen u_periodic
	(
		.clock              (clock),
		.rstn               (rstn),
		.tick_32k           (tick_32k),
		.periodic_rate_code (rate_reg),
		.periodic_event     (periodic_event)
	);

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	// next mode value, also feeds the irq register so it never lags an enable write
	always_comb
	begin
		mode_next = mode_reg;
		if (wr_en && addr == RTCF_MODE_CONTROL_OFS)
			mode_next = wdata & RTCF_MODE_WRITE_MASK; // bit 3 reserved, reads zero
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			mode_reg <= RTCF_MODE_RESET;
		else
			mode_reg <= mode_next;
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			rate_reg <= RTCF_RATE_RESET;
		else if (wr_en && addr == RTCF_RATE_DIV_OFS)
			rate_reg <= wdata[3:0];
	end

	// ----------------------------------------
	// mode outputs
	// ----------------------------------------
	// inhibit time advance
	assign update_advance = second_tick & ~mode_reg[RTCF_MODE_INHIBIT_BIT];
	assign binary_mode    = mode_reg[RTCF_MODE_BINARY_BIT];
	// conversion only, counters never see a change
	assign hour_24_mode   = mode_reg[RTCF_MODE_HOUR24_BIT];
	assign dst_enable     = mode_reg[RTCF_MODE_DST_BIT];

	// ----------------------------------------
	// event flags
	// ----------------------------------------
	assign flags_read = rd_en && addr == RTCF_EVENT_FLAGS_OFS;

	always_comb
	begin
		flags_next = flags_read ? 3'h0 : flags_reg;
		// an event in the clearing cycle survives the read
		flags_next = flags_next | {periodic_event, alarm_event, update_done};
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			flags_reg <= RTCF_FLAGS_RESET;
		else
			flags_reg <= flags_next;
	end

	assign enables = {mode_reg[RTCF_MODE_PIE_BIT], mode_reg[RTCF_MODE_AIE_BIT],
		mode_reg[RTCF_MODE_UIE_BIT]};

	assign req_flag = |(flags_reg & enables);

	// interrupt follows request
	// next flags and next enables, so irq equals the request flag in every cycle
	always_ff @(posedge clock)
	begin
		if (!rstn)
			irq <= 1'b0;
		else
			irq <= |(flags_next & {mode_next[RTCF_MODE_PIE_BIT], mode_next[RTCF_MODE_AIE_BIT],
				mode_next[RTCF_MODE_UIE_BIT]});
	end

	// ----------------------------------------
	// read path, data one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
			rdata <= 8'h00;
		else if (rd_en)
		begin
			case (addr)
				RTCF_RATE_DIV_OFS:     rdata <= {4'h0, rate_reg};
				RTCF_MODE_CONTROL_OFS: rdata <= mode_reg;
				RTCF_EVENT_FLAGS_OFS:  rdata <= {req_flag, flags_reg, 4'h0};
				default:               rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end
endmodule

// File: rtl/rtcf_pkg.sv
package rtcf_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] RTCF_RATE_DIV_OFS     = 8'h0A;
	localparam logic [7:0] RTCF_MODE_CONTROL_OFS = 8'h0B;
	localparam logic [7:0] RTCF_EVENT_FLAGS_OFS  = 8'h0C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int RTCF_MODE_INHIBIT_BIT  = 7;
	localparam int RTCF_MODE_PIE_BIT      = 6;
	localparam int RTCF_MODE_AIE_BIT      = 5;
	localparam int RTCF_MODE_UIE_BIT      = 4;
	localparam int RTCF_MODE_BINARY_BIT   = 2;
	localparam int RTCF_MODE_HOUR24_BIT   = 1;
	localparam int RTCF_MODE_DST_BIT      = 0;
	localparam int RTCF_FLAG_IRQ_BIT      = 7;
	localparam int RTCF_FLAG_PERIODIC_BIT = 6;
	localparam int RTCF_FLAG_ALARM_BIT    = 5;
	localparam int RTCF_FLAG_UPDATE_BIT   = 4;

	// ----------------------------------------
	// reset values and masks
	// ----------------------------------------
	localparam logic [7:0] RTCF_MODE_RESET      = 8'h00;
	localparam logic [3:0] RTCF_RATE_RESET      = 4'h0;
	localparam logic [2:0] RTCF_FLAGS_RESET     = 3'h0;
	localparam logic [7:0] RTCF_MODE_WRITE_MASK = 8'hF7;

	// ----------------------------------------
	// rate code table: code 3 is the shortest period, each step doubles
	// ----------------------------------------
	localparam logic [3:0] RTCF_RATE_FIRST   = 4'h3;
	localparam logic [3:0] RTCF_RATE_ALIAS_1 = 4'h8;
	localparam logic [3:0] RTCF_RATE_ALIAS_2 = 4'h9;
	// 32768 Hz tick count per period of code 3 (122.070 us)
	localparam int         RTCF_BASE_TICKS   = 4;
	localparam int         RTCF_DIV_WIDTH    = 16;

endpackage

// File: rtl/rtcf_periodic_gen.sv
`timescale 1ns/10ps
module rtcf_periodic_gen
	import rtcf_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       tick_32k,
	input  wire logic [3:0] periodic_rate_code,
	output logic            periodic_event
);
	logic [RTCF_DIV_WIDTH-1:0] div_reg;
	logic [RTCF_DIV_WIDTH-1:0] period_ticks;
	logic [3:0]                eff_code;

	// ----------------------------------------
	// rate decode
	// ----------------------------------------
	// rate code decode
	always_comb
	begin
		eff_code = periodic_rate_code;
		if (periodic_rate_code == 4'h1)
			eff_code = RTCF_RATE_ALIAS_1;
		else if (periodic_rate_code == 4'h2)
			eff_code = RTCF_RATE_ALIAS_2;
		period_ticks = RTCF_DIV_WIDTH'(RTCF_BASE_TICKS) << (eff_code - RTCF_RATE_FIRST);
	end

	// ----------------------------------------
	// divider of the 32 kHz tick
	// ----------------------------------------
	// divide slow clock
	always_ff @(posedge clock)
	begin
		if (!rstn || periodic_rate_code == 4'h0)
		begin
			div_reg        <= '0;
			periodic_event <= 1'b0;
		end
		else if (tick_32k)
		begin
			// restart on the last tick so a code change takes effect within one period
			if (div_reg >= period_ticks - 1'b1)
			begin
				div_reg        <= '0;
				periodic_event <= 1'b1;
			end
			else
			begin
				div_reg        <= div_reg + 1'b1;
				periodic_event <= 1'b0;
			end
		end
		else
			periodic_event <= 1'b0;
	end
endmodule

// File: tb/rtcf_monitor.sv
`timescale 1ns/10ps
module rtcf_monitor
(
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       second_tick,
	input wire logic       alarm_event,
	input wire logic       update_done,
	input wire logic       update_advance,
	input wire logic       binary_mode,
	input wire logic       hour_24_mode,
	input wire logic       dst_enable,
	input wire logic       irq
);
	// mode mirror, since the enables never reach the ports
	logic [7:0] mode_m;
	wire        rd_c = rd_en && addr == 8'h0C;
	always_ff @(posedge clock)
	begin
		if (!rstn) mode_m <= 8'h00;
		else if (wr_en && addr == 8'h0B) mode_m <= wdata & 8'hF7;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	inhibit_gate_a: assert property (update_advance == (second_tick && !mode_m[7]))
		else $error("advance gating");
	format_out_a: assert property (wr_en && addr == 8'h0B |=>
		{binary_mode, hour_24_mode, dst_enable} == $past(wdata[2:0])) else $error("mode outputs");
	alarm_irq_a: assert property (alarm_event |=> irq || !mode_m[5])
		else $error("alarm irq");
	update_irq_a: assert property (update_done |=> irq || !mode_m[4])
		else $error("update irq");
	irq_fall_a: assert property ($fell(irq) |-> $past(rd_c || wr_en))
		else $error("irq drop");
	irq_cause_a: assert property ($rose(irq) |-> $past(wr_en || mode_m[6]
		|| alarm_event && mode_m[5] || update_done && mode_m[4])) else $error("irq cause");
	flag_read_a: assert property (rd_c |=> rdata[7] == $past(irq) && rdata[3:0] == 4'h0)
		else $error("flag read");
	masked_alarm_a: assert property (alarm_event && !mode_m[6:4] && !irq && !wr_en |=> !irq)
		else $error("masked alarm");
	// main scenarios reached
	cover property (alarm_event && mode_m[5]);
	cover property (rd_c && irq);
	cover property (second_tick && mode_m[7]);
endmodule
bind rtcf_control rtcf_monitor i_rtcf_monitor
(
	.clock          (clock),
	.rstn           (rstn),
	.addr           (addr),
	.wdata          (wdata),
	.wr_en          (wr_en),
	.rd_en          (rd_en),
	.rdata          (rdata),
	.second_tick    (second_tick),
	.alarm_event    (alarm_event),
	.update_done    (update_done),
	.update_advance (update_advance),
	.binary_mode    (binary_mode),
	.hour_24_mode   (hour_24_mode),
	.dst_enable     (dst_enable),
	.irq            (irq)
);

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic       clock = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, tick_32k = 1'b0;
	logic       second_tick = 1'b0, alarm_event = 1'b0, update_done = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       update_advance, binary_mode, hour_24_mode, dst_enable, irq;
	logic [2:0] tdiv = 3'h0;
	logic [3:0] codes [5] = '{4'h0, 4'h3, 4'h4, 4'h1, 4'h2};
	// clocks per period: 4 ticks at code 3, doubling; 1 and 2 behave as 8 and 9
	int         per [5] = '{256, 32, 64, 1024, 2048};
	int         fail_count = 0, n_checks = 0, cyc = 0;
	rtcf_control i_rtcf_control
	(
		.clock          (clock),
		.rstn           (rstn),
		.addr           (addr),
		.wdata          (wdata),
		.wr_en          (wr_en),
		.rd_en          (rd_en),
		.rdata          (rdata),
		.tick_32k       (tick_32k),
		.second_tick    (second_tick),
		.alarm_event    (alarm_event),
		.update_done    (update_done),
		.update_advance (update_advance),
		.binary_mode    (binary_mode),
		.hour_24_mode   (hour_24_mode),
		.dst_enable     (dst_enable),
		.irq            (irq)
	);
	always #25 clock = ~clock;
	// tick every 8 clocks instead of 32 kHz keeps long codes short; cycle ceiling
	always @(posedge clock)
	begin
		tdiv <= tdiv + 3'h1;
		tick_32k <= tdiv == 3'h7;
		cyc <= cyc + 1;
		fail_count += int'(cyc == 10000);
		if (cyc == 10000) summarize();
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		fail_count += int'(s !== e);
		if (s !== e) $display("mismatch at %0t: seen %h expected %h", $time, s, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) {addr, wdata, wr_en} <= {a, d, 1'b1};
		@(posedge clock) wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock) {addr, rd_en} <= {a, 1'b1};
		@(posedge clock) rd_en <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// one-cycle event pulse, {alarm, update, second}, gated advance seen mid-pulse
	task automatic ev(input logic [2:0] v, input logic e);
		@(posedge clock) {alarm_event, update_done, second_tick} <= v;
		#1 chk({7'h00, update_advance}, {7'h00, e});
		@(posedge clock) {alarm_event, update_done, second_tick} <= 3'h0;
	endtask
	task automatic summarize();
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		rd(8'h0B, 8'h00);
		rd(8'h0C, 8'h00);
		rd(8'h0A, 8'h00);
		rd(8'h3F, 8'h00);
		wr(8'h0B, 8'hFF);
		rd(8'h0B, 8'hF7);
		#1 chk({5'h00, binary_mode, hour_24_mode, dst_enable}, 8'h07);
		ev(3'h1, 1'b0);
		wr(8'h0B, 8'h00);
		ev(3'h1, 1'b1);
		ev(3'h4, 1'b0);
		ev(3'h2, 1'b0);
		#1 chk({7'h00, irq}, 8'h00);
		rd(8'h0C, 8'h30);
		rd(8'h0C, 8'h00);
		wr(8'h0B, 8'h20);
		ev(3'h4, 1'b0);
		#1 chk({7'h00, irq}, 8'h01);
		wr(8'h0B, 8'h26);
		#1 chk({5'h00, binary_mode, hour_24_mode, dst_enable}, 8'h06);
		rd(8'h0C, 8'hA0);
		#1 chk({7'h00, irq}, 8'h00);
		wr(8'h0B, 8'h10);
		#1 chk({5'h00, binary_mode, hour_24_mode, dst_enable}, 8'h00);
		ev(3'h2, 1'b0);
		rd(8'h0C, 8'h90);
		wr(8'h0B, 8'h40);
		foreach (codes[i])
		begin
			wr(8'h0A, 8'h00);
			wr(8'h0A, {4'h0, codes[i]});
			rd(8'h0A, {4'h0, codes[i]});
			repeat (per[i] / 2) @(posedge clock);
			rd(8'h0C, 8'h00);
			repeat (per[i] * 3 / 4) @(posedge clock);
			rd(8'h0C, codes[i] == 4'h0 ? 8'h00 : 8'hC0);
		end
		summarize();
	end
endmodule
